// file: dv/tb_top.sv
// Self-checking bench for the serial control block
`timescale 1ns/10ps
`default_nettype none
module tb_top import usc_pkg::*; ;
	logic        core_clk = 1'b0, arst_n = 1'b0, t1_ovf_i = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rem_cap;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        txd_o, rxd_i, rxd_o, rxd_oe, irq_o, rem_line;
	int          num_errors = 0, samples_checked = 0;
	assign rxd_i = rxd_oe ? rxd_o : rem_line;
	initial forever #25 core_clk = ~core_clk;
	usc_uart i_usc_uart (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd_o, .rxd_i, .rxd_o, .rxd_oe,
		.t1_ovf_i, .irq_o);
	usc_remote i_usc_remote (.core_clk, .shclk(txd_o), .dat_in(rxd_o), .dat_oe(rxd_oe),
		.line_o(rem_line), .cap_ff(rem_cap));
	task automatic test_done;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			num_errors++;
			$display("unexpected at %0t: wait ran out got %h exp %h", $time, n, lim);
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		logic [1:0] r;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		tmo(n, 100);
		chk(32'(r), 32'(er));
	endtask
	// Read and compare the masked word
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFF,
		input logic [1:0] er = RESP_OKAY);
		int n;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		tmo(n, 100);
		chk(32'(r), 32'(er));
		chk(d & m, e);
	endtask
	// sel 0 watches the shift clock pin, sel 1 the interrupt
	task automatic wt(input logic sel, input logic lvl, input int lim, output int n);
		for (n = 0; n < lim; n++) begin
			@(posedge core_clk);
			if ((sel ? irq_o : txd_o) === lvl) break;
		end
	endtask
	task automatic frame(input logic [7:0] d);
		i_usc_remote.send({2'b11, d, 1'b0}, 16);
		repeat (32) @(posedge core_clk);
	endtask
	task automatic t_reset;
		rc(ADDR_SCTRL, 32'h0, 32'hFFFFFFFF);
		rc(8'h1C, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		chk(32'(txd_o), 32'h1);
	endtask
	task automatic t_pwr;
		wr(ADDR_PWR, 32'hFF);
		rc(ADDR_PWR, 32'hC0, 32'hFFFFFFFF);
		wr(ADDR_PWR, 32'h40);
		rc(ADDR_PWR, 32'h40);
	endtask
	task automatic t_idle;
		int n;
		wr(ADDR_SCTRL, 32'h20);
		wt(1'b0, 1'b0, 20, n);
		tmo(n, 20);
		chk(32'(n < 20), 32'h1);
		wr(ADDR_SCTRL, 32'h00);
		wt(1'b0, 1'b1, 20, n);
		tmo(n, 20);
		chk(32'(n < 20), 32'h1);
	endtask
	task automatic t_tx0;
		int n, n1, n2;
		wr(ADDR_PWR, 32'h00);
		wr(ADDR_IMASK, 32'h02);
		wr(ADDR_DATA, 32'hA5);
		wt(1'b0, 1'b0, 20, n);
		tmo(n, 20);
		// The rate divider runs free, so the first bit may be short: time the second
		wt(1'b0, 1'b1, 20, n);
		tmo(n, 20);
		wt(1'b0, 1'b0, 20, n);
		tmo(n, 20);
		wt(1'b0, 1'b1, 20, n1);
		wt(1'b0, 1'b0, 20, n2);
		chk(32'(n1 + n2 + 2), 32'h4);
		wt(1'b1, 1'b1, 100, n);
		tmo(n, 100);
		chk(32'(rem_cap), 32'hA5);
		rc(ADDR_SCTRL, 32'h02, 32'h02);
		wr(ADDR_ISTAT, 32'h02);
		chk(32'(irq_o), 32'h0);
	endtask
	task automatic t_t1;
		int n;
		wr(ADDR_SCTRL, 32'h08);
		wr(ADDR_DATA, 32'h3C);
		// Without overflow pulses the shift clock stays in its first half
		wt(1'b0, 1'b1, 40, n);
		chk(32'(n), 32'd40);
		t1_ovf_i <= 1'b1;
		wt(1'b1, 1'b1, 200, n);
		tmo(n, 200);
		t1_ovf_i <= 1'b0;
		chk(32'(rem_cap), 32'h3C);
		wr(ADDR_ISTAT, 32'h02);
	endtask
	task automatic t_rx;
		wr(ADDR_PWR, 32'h80);
		wr(ADDR_GIVEN, 32'h5A);
		wr(ADDR_BCAST, 32'h77);
		wr(ADDR_SCTRL, 32'hA0);
		frame(8'h5A);
		rc(ADDR_SCTRL, 32'hA0);
		wr(ADDR_SCTRL, 32'hB0);
		frame(8'h33);
		rc(ADDR_SCTRL, 32'h00, 32'h01);
		frame(8'h5A);
		rc(ADDR_SCTRL, 32'hB5);
		rc(ADDR_DATA, 32'h5A);
		chk(32'(irq_o), 32'h0);
		wr(ADDR_SCTRL, 32'hB0);
		frame(8'h77);
		rc(ADDR_SCTRL, 32'h01, 32'h01);
	endtask
	// Eight-bit mode on Timer 1, then a bad stop bit with framing select on
	task automatic t_m1;
		t1_ovf_i <= 1'b1;
		wr(ADDR_SCTRL, 32'h50);
		frame(8'hC3);
		rc(ADDR_SCTRL, 32'h55);
		rc(ADDR_DATA, 32'hC3);
		wr(ADDR_PWR, 32'hC0);
		wr(ADDR_SCTRL, 32'h50);
		i_usc_remote.send({2'b10, 8'h3C, 1'b0}, 16);
		repeat (32) @(posedge core_clk);
		rc(ADDR_SCTRL, 32'hD1);
		t1_ovf_i <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset();
		t_pwr();
		t_idle();
		t_tx0();
		t_t1();
		t_rx();
		t_m1();
		test_done();
	end
endmodule
`default_nettype wire

// file: dv/usc_remote.sv
// Remote serial device on the line side
`timescale 1ns/10ps
`default_nettype none
module usc_remote (
	// Clock
	input wire logic  core_clk,
	// Line
	input wire logic  shclk,
	input wire logic  dat_in,
	input wire logic  dat_oe,
	output logic      line_o,
	output logic [7:0] cap_ff
);
	// Released line reads high through its pull-up
	initial line_o = 1'b1;
	initial cap_ff = 8'h00;
	// Shift data is stable on the return to idle, LSB arrives first
	always @(posedge shclk) if (dat_oe) cap_ff <= {dat_in, cap_ff[7:1]};
	task automatic send(input logic [10:0] bits, input int cyc);
		for (int i = 0; i < 11; i++) begin
			line_o <= bits[i];
			repeat (cyc) @(posedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// file: dv/usc_uart_sva.sv
// Register bus and pin timing checks for the serial control block
`timescale 1ns/10ps
`default_nettype none
module usc_uart_sva import usc_pkg::*; (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        arst_n,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Serial pins
	input wire logic        rxd_o,
	input wire logic        rxd_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped early");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		|-> s_axi_rdata == 32'h00000000) else $error("error read carries data");
	a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
	a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_line_release: assert property (!rxd_oe |-> rxd_o)
		else $error("released data line not high");
endmodule
bind usc_uart usc_uart_sva i_usc_uart_sva (.*);
`default_nettype wire

// file: hdl/usc_baud.sv
// Bit-rate tick generator: half-bit ticks in sync mode, 16x ticks otherwise
`timescale 1ns/10ps
`default_nettype none
module usc_baud import usc_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Core side
	usc_baud_if.gen  bif
);
	logic src;
	logic ph_ff;
	logic nxt_ph;

	// Fixed nine-bit mode and sync mode without ninth-bit control count system cycles, the others count Timer 1 overflows
	always_comb begin
		src = ((bif.mode == MODE_SYNC) && !bif.tx_ninth) || (bif.mode == MODE_9FIX) ? 1'b1
			: bif.t1_ovf;
		nxt_ph = src ? !ph_ff : ph_ff;
	end

	// Doubler passes every source pulse, otherwise every second one
	assign bif.tick = src && (bif.doubler || ph_ff);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_ff <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
		end
	end
endmodule
`default_nettype wire

// file: hdl/usc_baud_if.sv
// Link between the control core and the bit-rate tick generator
`timescale 1ns/10ps
`default_nettype none
interface usc_baud_if;
	logic [1:0] mode;
	logic       doubler;
	logic       tx_ninth;
	logic       t1_ovf;
	logic       tick;

	modport gen  (input mode, input doubler, input tx_ninth, input t1_ovf, output tick);
	modport user (output mode, output doubler, output tx_ninth, output t1_ovf, input tick);
endinterface
`default_nettype wire

// file: hdl/usc_pkg.sv
// Shared constants and types of the serial control block
package usc_pkg;
	// AXI4-Lite register map (byte addresses)
	localparam int unsigned AXI_AW     = 8;
	localparam logic [7:0]  ADDR_SCTRL = 8'h00;
	localparam logic [7:0]  ADDR_PWR   = 8'h04;
	localparam logic [7:0]  ADDR_DATA  = 8'h08;
	localparam logic [7:0]  ADDR_GIVEN = 8'h0C;
	localparam logic [7:0]  ADDR_BCAST = 8'h10;
	localparam logic [7:0]  ADDR_ISTAT = 8'h14;
	localparam logic [7:0]  ADDR_IMASK = 8'h18;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Serial control register fields
	localparam int unsigned SC_MODE_HI = 7;
	localparam int unsigned SC_MODE_LO = 6;
	localparam int unsigned SC_MPC     = 5;
	localparam int unsigned SC_REN     = 4;
	localparam int unsigned SC_TX9     = 3;
	localparam int unsigned SC_RX9     = 2;
	localparam int unsigned SC_TXD     = 1;
	localparam int unsigned SC_RXD     = 0;
	// Power control register fields
	localparam int unsigned PW_DBL  = 7;
	localparam int unsigned PW_FSEL = 6;
	// Interrupt status and mask fields
	localparam int unsigned IST_RX = 0;
	localparam int unsigned IST_TX = 1;
	localparam int unsigned IST_W  = 2;

	// Reset values
	localparam logic [7:0]        BYTE_RST = 8'h00;
	localparam logic [1:0]        MODE_RST = 2'h0;
	localparam logic [IST_W-1:0]  IST_RST  = 2'h0;

	// Serial modes
	localparam logic [1:0] MODE_SYNC = 2'h0;
	localparam logic [1:0] MODE_8BIT = 2'h1;
	localparam logic [1:0] MODE_9FIX = 2'h2;
	localparam logic [1:0] MODE_9VAR = 2'h3;

	// Bit timing counts
	localparam logic [3:0] OS_LAST     = 4'hF;
	localparam logic [3:0] OS_MID      = 4'h7;
	localparam logic [3:0] CNT_ZERO    = 4'h0;
	localparam logic [3:0] CNT_ONE     = 4'h1;
	localparam logic [3:0] SYNC_LAST   = 4'h7;
	localparam logic [3:0] TX8_LAST    = 4'h9;
	localparam logic [3:0] TX9_LAST    = 4'hA;
	localparam logic [3:0] RX8_LAST    = 4'h8;
	localparam logic [3:0] RX9_LAST    = 4'h9;

	typedef enum logic [1:0] {SH_IDLE, SH_ASYNC, SH_SYNC} usc_sh_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} usc_rx_state_t;
endpackage

// file: hdl/usc_uart.sv
// Serial port control core with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Sync shift clock idles at inverted check bit
// - Nine-bit check mode: flag only on address match
// - Sync mode ninth-bit control picks Timer 1
// - Received ninth bit stored, unused in sync
// - Sync transmit done set after eighth bit
// - Doubler bit at power control bit 7
// - Framing select at power control bit 6
// - Nine-bit modes: nine data then stop
// - Sync default rate is quarter system clock
module usc_uart import usc_pkg::*; (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	// AXI4-Lite write address and data
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Serial pins
	output logic                   txd_o,
	input  wire logic              rxd_i,
	output logic                   rxd_o,
	output logic                   rxd_oe,
	// Timer 1 overflow pulse
	input  wire logic              t1_ovf_i,
	// Interrupt
	output logic                   irq_o
);
	usc_baud_if bif();

	// Control and status
	logic [1:0]        mode_ff, nxt_mode;
	logic              mpc_ff, nxt_mpc;
	logic              ren_ff, nxt_ren;
	logic              tx9_ff, nxt_tx9;
	logic              rx9_ff, nxt_rx9;
	logic              txdone_ff, nxt_txdone;
	logic              rxdone_ff, nxt_rxdone;
	logic              fe_ff, nxt_fe;
	logic              dbl_ff, nxt_dbl;
	logic              fsel_ff, nxt_fsel;
	logic [7:0]        given_ff, nxt_given;
	logic [7:0]        bcast_ff, nxt_bcast;
	logic [7:0]        rxdata_ff, nxt_rxdata;
	logic [IST_W-1:0]  ist_ff, nxt_ist;
	logic [IST_W-1:0]  imask_ff, nxt_imask;
	// Bus slave
	logic              aw_got_ff, nxt_aw_got;
	logic              w_got_ff, nxt_w_got;
	logic [AXI_AW-1:0] waddr_ff, nxt_waddr;
	logic [7:0]        wdata_ff, nxt_wdata;
	logic              wlane_ff, nxt_wlane;
	logic              bvalid_ff, nxt_bvalid;
	logic [1:0]        bresp_ff, nxt_bresp;
	logic              rvalid_ff, nxt_rvalid;
	logic [7:0]        rdata_ff, nxt_rdata;
	logic [1:0]        rresp_ff, nxt_rresp;
	// Transmit and sync shift engine
	usc_sh_state_t     sh_state_ff, nxt_sh_state;
	logic [10:0]       sh_ff, nxt_sh;
	logic [3:0]        sh_bits_ff, nxt_sh_bits;
	logic [3:0]        sh_sub_ff, nxt_sh_sub;
	logic              m0_rx_ff, nxt_m0_rx;
	logic              ph_ff, nxt_ph;
	// Asynchronous receiver
	usc_rx_state_t     rx_state_ff, nxt_rx_state;
	logic [9:0]        rx_sh_ff, nxt_rx_sh;
	logic [3:0]        rx_bits_ff, nxt_rx_bits;
	logic [3:0]        rx_sub_ff, nxt_rx_sub;
	logic              rx_s1_ff, nxt_rx_s1;
	logic              rx_s2_ff, nxt_rx_s2;
	logic              rx_prev_ff, nxt_rx_prev;
	// Registered pins
	logic              txd_ff, nxt_txd;
	logic              rxdo_ff, nxt_rxdo;
	logic              rxoe_ff, nxt_rxoe;

	logic              wr_do;
	logic              tick;
	logic              tx_evt;
	logic              rx_evt;
	logic              rx_ok;
	logic              stop_bit;
	logic [7:0]        rx_byte;
	logic              rx_ninth;
	logic [9:0]        rx_shifted;
	logic              sclk;

	assign bif.mode     = mode_ff;
	assign bif.doubler  = dbl_ff;
	assign bif.tx_ninth = tx9_ff;
	assign bif.t1_ovf   = t1_ovf_i;
	assign tick         = bif.tick;

	usc_baud u_baud (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.bif      (bif)
	);

	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = !w_got_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = {24'h000000, rdata_ff};
	assign wr_do         = aw_got_ff && w_got_ff;
	assign irq_o         = |(ist_ff & imask_ff);
	assign txd_o         = txd_ff;
	assign rxd_o         = rxdo_ff;
	assign rxd_oe        = rxoe_ff;

	always_comb begin
		nxt_mode = mode_ff;     nxt_mpc = mpc_ff;         nxt_ren = ren_ff;
		nxt_tx9 = tx9_ff;       nxt_rx9 = rx9_ff;         nxt_txdone = txdone_ff;
		nxt_rxdone = rxdone_ff; nxt_fe = fe_ff;           nxt_dbl = dbl_ff;
		nxt_fsel = fsel_ff;     nxt_given = given_ff;     nxt_bcast = bcast_ff;
		nxt_rxdata = rxdata_ff; nxt_ist = ist_ff;         nxt_imask = imask_ff;
		nxt_aw_got = aw_got_ff; nxt_w_got = w_got_ff;     nxt_waddr = waddr_ff;
		nxt_wdata = wdata_ff;   nxt_wlane = wlane_ff;     nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;   nxt_rvalid = rvalid_ff;   nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;   nxt_sh_state = sh_state_ff; nxt_sh = sh_ff;
		nxt_sh_bits = sh_bits_ff; nxt_sh_sub = sh_sub_ff; nxt_m0_rx = m0_rx_ff;
		nxt_ph = ph_ff;         nxt_rx_state = rx_state_ff; nxt_rx_sh = rx_sh_ff;
		nxt_rx_bits = rx_bits_ff; nxt_rx_sub = rx_sub_ff;
		nxt_rx_s1 = rxd_i;      nxt_rx_s2 = rx_s1_ff;     nxt_rx_prev = rx_s2_ff;
		tx_evt = 1'b0;
		rx_evt = 1'b0;
		rx_ok = 1'b0;
		stop_bit = 1'b1;
		rx_byte = rxdata_ff;
		rx_ninth = rx9_ff;
		rx_shifted = {rx_s2_ff, rx_sh_ff[9:1]};

		// Bus: address and data may arrive in either order
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_got = 1'b1;
			nxt_waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_got = 1'b1;
			nxt_wdata = s_axi_wdata[7:0];
			nxt_wlane = s_axi_wstrb[0];
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (wr_do) begin
			nxt_aw_got = 1'b0;
			nxt_w_got = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = RESP_OKAY;
			if (waddr_ff == ADDR_SCTRL) begin
				if (wlane_ff) begin
					// Framing select turns the top mode bit into the error flag
					if (fsel_ff) begin
						nxt_fe = wdata_ff[SC_MODE_HI];
					end else begin
						nxt_mode[1] = wdata_ff[SC_MODE_HI];
					end
					nxt_mode[0] = wdata_ff[SC_MODE_LO];
					nxt_mpc = wdata_ff[SC_MPC];
					nxt_ren = wdata_ff[SC_REN];
					nxt_tx9 = wdata_ff[SC_TX9];
					nxt_rx9 = wdata_ff[SC_RX9];
					nxt_txdone = wdata_ff[SC_TXD];
					nxt_rxdone = wdata_ff[SC_RXD];
				end
			end else if (waddr_ff == ADDR_PWR) begin
				if (wlane_ff) begin
					nxt_dbl = wdata_ff[PW_DBL];
					nxt_fsel = wdata_ff[PW_FSEL];
				end
			end else if (waddr_ff == ADDR_DATA) begin
				// A write while the shifter is busy is dropped
				if (wlane_ff && sh_state_ff == SH_IDLE) begin
					nxt_sh_bits = CNT_ZERO;
					nxt_sh_sub = CNT_ZERO;
					nxt_ph = 1'b0;
					nxt_m0_rx = 1'b0;
					if (mode_ff == MODE_SYNC) begin
						nxt_sh_state = SH_SYNC;
						nxt_sh = {3'h7, wdata_ff};
					end else begin
						nxt_sh_state = SH_ASYNC;
						nxt_sh = {1'b1, (mode_ff == MODE_8BIT) || tx9_ff, wdata_ff, 1'b0};
					end
				end
			end else if (waddr_ff == ADDR_GIVEN) begin
				if (wlane_ff) begin
					nxt_given = wdata_ff;
				end
			end else if (waddr_ff == ADDR_BCAST) begin
				if (wlane_ff) begin
					nxt_bcast = wdata_ff;
				end
			end else if (waddr_ff == ADDR_ISTAT) begin
				if (wlane_ff) begin
					nxt_ist = ist_ff & ~wdata_ff[IST_W-1:0];
				end
			end else if (waddr_ff == ADDR_IMASK) begin
				if (wlane_ff) begin
					nxt_imask = wdata_ff[IST_W-1:0];
				end
			end else begin
				nxt_bresp = RESP_SLVERR;
			end
		end

		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = RESP_OKAY;
			nxt_rdata = BYTE_RST;
			if (s_axi_araddr == ADDR_SCTRL) begin
				nxt_rdata = {fsel_ff ? fe_ff : mode_ff[1], mode_ff[0], mpc_ff, ren_ff,
					tx9_ff, rx9_ff, txdone_ff, rxdone_ff};
			end else if (s_axi_araddr == ADDR_PWR) begin
				nxt_rdata = {dbl_ff, fsel_ff, 6'h00};
			end else if (s_axi_araddr == ADDR_DATA) begin
				nxt_rdata = rxdata_ff;
			end else if (s_axi_araddr == ADDR_GIVEN) begin
				nxt_rdata = given_ff;
			end else if (s_axi_araddr == ADDR_BCAST) begin
				nxt_rdata = bcast_ff;
			end else if (s_axi_araddr == ADDR_ISTAT) begin
				nxt_rdata = {6'h00, ist_ff};
			end else if (s_axi_araddr == ADDR_IMASK) begin
				nxt_rdata = {6'h00, imask_ff};
			end else begin
				nxt_rresp = RESP_SLVERR;
			end
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end

		// Sync reception starts only when enabled and the last byte was taken
		if (sh_state_ff == SH_IDLE && nxt_sh_state == SH_IDLE && mode_ff == MODE_SYNC
			&& ren_ff && !rxdone_ff) begin
			nxt_sh_state = SH_SYNC;
			nxt_m0_rx = 1'b1;
			nxt_sh_bits = CNT_ZERO;
			nxt_ph = 1'b0;
		end

		case (sh_state_ff)
			SH_SYNC: begin
				if (tick) begin
					nxt_ph = !ph_ff;
					if (!ph_ff) begin
						if (m0_rx_ff) begin
							nxt_sh = {3'h7, rx_s2_ff, sh_ff[7:1]};
						end
					end else begin
						if (!m0_rx_ff) begin
							nxt_sh = {1'b1, sh_ff[10:1]};
						end
						nxt_sh_bits = sh_bits_ff + CNT_ONE;
						if (sh_bits_ff == SYNC_LAST) begin
							nxt_sh_state = SH_IDLE;
							if (m0_rx_ff) begin
								rx_evt = 1'b1;
								rx_ok = 1'b1;
								rx_byte = sh_ff[7:0];
							end else begin
								tx_evt = 1'b1;
							end
						end
					end
				end
			end
			SH_ASYNC: begin
				if (tick) begin
					nxt_sh_sub = sh_sub_ff + CNT_ONE;
					if (sh_sub_ff == OS_LAST) begin
						nxt_sh = {1'b1, sh_ff[10:1]};
						nxt_sh_bits = sh_bits_ff + CNT_ONE;
						if (sh_bits_ff == ((mode_ff == MODE_8BIT) ? TX8_LAST : TX9_LAST)) begin
							nxt_sh_state = SH_IDLE;
							tx_evt = 1'b1;
						end
					end
				end
			end
			default: begin
			end
		endcase

		case (rx_state_ff)
			RX_IDLE: begin
				if (mode_ff != MODE_SYNC && ren_ff && rx_prev_ff && !rx_s2_ff) begin
					nxt_rx_state = RX_START;
					nxt_rx_sub = CNT_ZERO;
				end
			end
			RX_START: begin
				if (tick) begin
					nxt_rx_sub = rx_sub_ff + CNT_ONE;
					if (rx_sub_ff == OS_MID) begin
						// A start bit gone high by mid-bit is treated as a glitch
						nxt_rx_state = rx_s2_ff ? RX_IDLE : RX_DATA;
						nxt_rx_sub = CNT_ZERO;
						nxt_rx_bits = CNT_ZERO;
					end
				end
			end
			RX_DATA: begin
				if (tick) begin
					nxt_rx_sub = rx_sub_ff + CNT_ONE;
					if (rx_sub_ff == OS_LAST) begin
						nxt_rx_sh = rx_shifted;
						nxt_rx_bits = rx_bits_ff + CNT_ONE;
						if (rx_bits_ff == ((mode_ff == MODE_8BIT) ? RX8_LAST : RX9_LAST)) begin
							nxt_rx_state = RX_IDLE;
							rx_evt = 1'b1;
							stop_bit = rx_shifted[9];
							if (mode_ff == MODE_8BIT) begin
								rx_byte = rx_shifted[8:1];
								rx_ninth = rx_shifted[9];
								rx_ok = !mpc_ff || stop_bit;
							end else begin
								rx_byte = rx_shifted[7:0];
								rx_ninth = rx_shifted[8];
								rx_ok = !mpc_ff || (rx_byte == given_ff)
									|| (rx_byte == bcast_ff);
							end
						end
					end
				end
			end
			default: begin
				nxt_rx_state = RX_IDLE;
			end
		endcase

		// Hardware sets win over a software clear in the same cycle
		if (rx_evt && !stop_bit) begin
			nxt_fe = 1'b1;
		end
		if (tx_evt) begin
			nxt_txdone = 1'b1;
			nxt_ist[IST_TX] = 1'b1;
		end
		if (rx_evt && rx_ok && !rxdone_ff) begin
			nxt_rxdone = 1'b1;
			nxt_ist[IST_RX] = 1'b1;
			nxt_rxdata = rx_byte;
			if (mode_ff != MODE_SYNC) begin
				nxt_rx9 = rx_ninth;
			end
		end

		// Shift clock leaves idle only in the first half of each bit
		sclk = (sh_state_ff == SH_SYNC && !ph_ff) ? mpc_ff : !mpc_ff;
		if (mode_ff == MODE_SYNC) begin
			nxt_txd = sclk;
		end else begin
			nxt_txd = (sh_state_ff == SH_ASYNC) ? sh_ff[0] : 1'b1;
		end
		nxt_rxoe = (sh_state_ff == SH_SYNC) && !m0_rx_ff;
		nxt_rxdo = nxt_rxoe ? sh_ff[0] : 1'b1;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff <= MODE_RST;   mpc_ff <= 1'b0;       ren_ff <= 1'b0;
			tx9_ff <= 1'b0;        rx9_ff <= 1'b0;       txdone_ff <= 1'b0;
			rxdone_ff <= 1'b0;     fe_ff <= 1'b0;        dbl_ff <= 1'b0;
			fsel_ff <= 1'b0;       given_ff <= BYTE_RST; bcast_ff <= BYTE_RST;
			rxdata_ff <= BYTE_RST; ist_ff <= IST_RST;    imask_ff <= IST_RST;
			aw_got_ff <= 1'b0;     w_got_ff <= 1'b0;     waddr_ff <= '0;
			wdata_ff <= BYTE_RST;  wlane_ff <= 1'b0;     bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY; rvalid_ff <= 1'b0;    rdata_ff <= BYTE_RST;
			rresp_ff <= RESP_OKAY; sh_state_ff <= SH_IDLE; sh_ff <= '1;
			sh_bits_ff <= CNT_ZERO; sh_sub_ff <= CNT_ZERO; m0_rx_ff <= 1'b0;
			ph_ff <= 1'b0;         rx_state_ff <= RX_IDLE; rx_sh_ff <= '0;
			rx_bits_ff <= CNT_ZERO; rx_sub_ff <= CNT_ZERO; rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;      rx_prev_ff <= 1'b1;   txd_ff <= 1'b1;
			rxdo_ff <= 1'b1;       rxoe_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;     mpc_ff <= nxt_mpc;       ren_ff <= nxt_ren;
			tx9_ff <= nxt_tx9;       rx9_ff <= nxt_rx9;       txdone_ff <= nxt_txdone;
			rxdone_ff <= nxt_rxdone; fe_ff <= nxt_fe;         dbl_ff <= nxt_dbl;
			fsel_ff <= nxt_fsel;     given_ff <= nxt_given;   bcast_ff <= nxt_bcast;
			rxdata_ff <= nxt_rxdata; ist_ff <= nxt_ist;       imask_ff <= nxt_imask;
			aw_got_ff <= nxt_aw_got; w_got_ff <= nxt_w_got;   waddr_ff <= nxt_waddr;
			wdata_ff <= nxt_wdata;   wlane_ff <= nxt_wlane;   bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;   rvalid_ff <= nxt_rvalid; rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;   sh_state_ff <= nxt_sh_state; sh_ff <= nxt_sh;
			sh_bits_ff <= nxt_sh_bits; sh_sub_ff <= nxt_sh_sub; m0_rx_ff <= nxt_m0_rx;
			ph_ff <= nxt_ph;         rx_state_ff <= nxt_rx_state; rx_sh_ff <= nxt_rx_sh;
			rx_bits_ff <= nxt_rx_bits; rx_sub_ff <= nxt_rx_sub; rx_s1_ff <= nxt_rx_s1;
			rx_s2_ff <= nxt_rx_s2;   rx_prev_ff <= nxt_rx_prev; txd_ff <= nxt_txd;
			rxdo_ff <= nxt_rxdo;     rxoe_ff <= nxt_rxoe;
		end
	end
endmodule
`default_nettype wire
